/* rtl/pin_change_pkg.sv */
// shared offsets, field positions and types for the pin change interrupt block
package pin_change_pkg;
    localparam int num_groups = 4;
    localparam logic [11:0] group_a_rise_enable_off = 12'h000;
    localparam logic [11:0] group_a_fall_enable_off = 12'h004;
    localparam logic [11:0] group_a_change_flags_off = 12'h008;
    localparam logic [11:0] group_b_rise_enable_off = 12'h010;
    localparam logic [11:0] group_b_fall_enable_off = 12'h014;
    localparam logic [11:0] group_b_change_flags_off = 12'h018;
    localparam logic [11:0] group_c_rise_enable_off = 12'h020;
    localparam logic [11:0] group_c_fall_enable_off = 12'h024;
    localparam logic [11:0] group_c_change_flags_off = 12'h028;
    localparam logic [11:0] group_e_rise_enable_off = 12'h030;
    localparam logic [11:0] group_e_fall_enable_off = 12'h034;
    localparam logic [11:0] group_e_change_flags_off = 12'h038;
    localparam logic [11:0] periph_irq_enable_0_off = 12'h040;
    localparam logic [11:0] periph_irq_request_0_off = 12'h044;
    localparam int group_stride_sh = 4;
    localparam int master_enable_bit = 4;
    localparam int summary_flag_bit = 4;
    localparam logic [7:0] group_e_mask = 8'h08;
    localparam logic [7:0] full_mask = 8'hff;
    localparam logic [7:0] reg8_reset = 8'h00;
    localparam logic [31:0] word_reset = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] rise_enable_reg;
        logic [7:0] fall_enable_reg;
    } edge_cfg_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;
endpackage

/* rtl/change_group.sv */
// one pin group: synchroniser, edge detect and hardware-set flag register
`timescale 1ns/10ps
module change_group
    import pin_change_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] pins,
    input wire logic [7:0] impl_mask,
    input wire edge_cfg_t cfg,
    input wire logic flag_wr,
    input wire logic [7:0] flag_wdata,
    output logic [7:0] change_flag_reg,
    output logic [7:0] edge_hit
);
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;

    // two stages before anything looks at the pin; prev holds the older sample
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= reg8_reset;
            sync2 <= reg8_reset;
            prev <= reg8_reset;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            prev <= sync2; // RULE17
        end
    end

    // enabled rising or falling edge; both enables clear gives nothing
    assign edge_hit = impl_mask & ((cfg.rise_enable_reg & sync2 & ~prev)
        | (cfg.fall_enable_reg & ~sync2 & prev)); // RULE3 RULE4 RULE5

    // a write stores its value, but an edge in the same cycle wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            change_flag_reg <= reg8_reset; // RULE15
        end else if (flag_wr) begin
            change_flag_reg <= (flag_wdata & impl_mask) | edge_hit; // RULE10 RULE11
        end else begin
            change_flag_reg <= change_flag_reg | edge_hit; // RULE6
        end
    end

    set_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (edge_hit != 8'h00) |=> ((change_flag_reg & $past(edge_hit)) == $past(edge_hit)))
        else $error("detected edge did not set its flag"); // RULE11

    edge_delay_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (cfg.rise_enable_reg[0] && impl_mask[0] && sync2[0] && !prev[0]
            && $stable(cfg)) |-> edge_hit[0])
        else $error("rising edge on bit zero not detected"); // RULE3

    no_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ((cfg.rise_enable_reg | cfg.fall_enable_reg) == 8'h00) |-> (edge_hit == 8'h00))
        else $error("edge reported with no enable"); // RULE5
endmodule

/* rtl/pin_change_interrupt.sv */
// pin change interrupt block with apb register access, interrupt and wake
//
// Notes on behaviour
// RULE1: change detection on every pin of groups a, b, c and pin three of e.
// RULE2: each group has rise enable, fall enable and flag registers, bit n = pin n.
// RULE3: a rise enable bit set makes its pin detect rising edges.
// RULE4: a fall enable bit set makes its pin detect falling edges.
// RULE5: both set detects both edges; both clear detects nothing.
// RULE6: an enabled edge sets the pin flag; interrupt only with master enable.
// RULE7: master enable lives in peripheral interrupt enable register zero.
// RULE8: with master enable clear, flags still set but no interrupt.
// RULE9: read-only summary flag is the or of every pin flag.
// RULE10: writing zero to a flag bit clears it.
// RULE11: an edge during a flag write leaves the flag set.
// RULE12: software clears flags by reading, xor with ones, and anding back.
// RULE13: with master enable set, a change interrupt wakes from sleep.
// RULE14: flags caught during sleep are updated before the first instruction.
// RULE15: all enables and flags reset to zero on every reset.
// RULE16: group e registers implement only bit three, others read zero.
// RULE17: pins are synchronised and edges found by comparing successive samples.
`timescale 1ns/10ps
module pin_change_interrupt
    import pin_change_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_group_a,
    input wire logic [7:0] pin_group_b,
    input wire logic [7:0] pin_group_c,
    input wire logic group_e_pin_three,
    output logic change_irq,
    output logic wake_req
);
    apb_req_t req;
    edge_cfg_t cfg [num_groups];
    logic [7:0] pins [num_groups];
    logic [7:0] masks [num_groups];
    logic [7:0] flags [num_groups];
    logic [7:0] hits [num_groups];
    logic [num_groups-1:0] flag_wr;
    logic [num_groups-1:0] rise_wr;
    logic [num_groups-1:0] fall_wr;
    logic wr_fire;
    logic rd_fire;
    logic addr_ok;
    logic [1:0] grp;
    logic [1:0] sub;
    logic change_irq_master_enable;
    logic change_summary_flag;
    logic [31:0] next_rdata;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    // group e carries only its pin three
    assign pins[0] = pin_group_a;
    assign pins[1] = pin_group_b;
    assign pins[2] = pin_group_c;
    assign pins[3] = {4'h0, group_e_pin_three, 3'h0}; // RULE1
    assign masks[0] = full_mask;
    assign masks[1] = full_mask;
    assign masks[2] = full_mask;
    assign masks[3] = group_e_mask; // RULE16

    // zero wait states, so every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_fire = req.sel && req.enable && req.write && pstrb[0];
    assign rd_fire = req.sel && req.enable && !req.write;
    assign grp = req.addr[5:4];
    assign sub = req.addr[3:2];

    // decode: group slots at 0x00..0x38, enable and request words at 0x40/0x44
    always_comb begin
        addr_ok = 1'b0;
        if (req.addr[1:0] == 2'h0) begin
            if (req.addr[11:6] == 6'h00) begin
                addr_ok = (sub != 2'h3);
            end else if (req.addr == periph_irq_enable_0_off
                || req.addr == periph_irq_request_0_off) begin
                addr_ok = 1'b1;
            end
        end
    end

    assign pslverr = req.sel && req.enable && !addr_ok;

    // per-group write strobes; the bus index follows the group stride
    always_comb begin
        for (int g = 0; g < num_groups; g++) begin
            rise_wr[g] = wr_fire && addr_ok && req.addr[11:6] == 6'h00
                && grp == g[1:0] && sub == 2'h0;
            fall_wr[g] = wr_fire && addr_ok && req.addr[11:6] == 6'h00
                && grp == g[1:0] && sub == 2'h1;
            flag_wr[g] = wr_fire && addr_ok && req.addr[11:6] == 6'h00
                && grp == g[1:0] && sub == 2'h2;
        end
    end

    // edge enable registers, one pair per group, masked to implemented bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int g = 0; g < num_groups; g++) begin
                cfg[g] <= '{rise_enable_reg: reg8_reset, fall_enable_reg: reg8_reset}; // RULE15
            end
        end else begin
            for (int g = 0; g < num_groups; g++) begin
                if (rise_wr[g]) begin
                    cfg[g].rise_enable_reg <= req.wdata[7:0] & masks[g]; // RULE2 RULE16
                end
                if (fall_wr[g]) begin
                    cfg[g].fall_enable_reg <= req.wdata[7:0] & masks[g]; // RULE2 RULE16
                end
            end
        end
    end

    // one instance per group keeps the edge and flag logic in a single place
    for (genvar g = 0; g < num_groups; g++) begin : grp_inst
        change_group u_group (
            .mclk(mclk),
            .rst_b(rst_b),
            .pins(pins[g]),
            .impl_mask(masks[g]),
            .cfg(cfg[g]),
            .flag_wr(flag_wr[g]),
            .flag_wdata(req.wdata[7:0]),
            .change_flag_reg(flags[g]),
            .edge_hit(hits[g])
        );
    end

    // master enable in the peripheral interrupt enable word
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            change_irq_master_enable <= 1'b0;
        end else if (wr_fire && req.addr == periph_irq_enable_0_off) begin
            change_irq_master_enable <= req.wdata[master_enable_bit]; // RULE7
        end
    end

    // summary is pure combination of flags, so it cannot drift from them
    assign change_summary_flag = (flags[0] | flags[1] | flags[2] | flags[3]) != 8'h00; // RULE9

    // a level interrupt; wake uses the same term because the flags are updated
    // on the system clock before the core can fetch its first instruction
    assign change_irq = change_summary_flag && change_irq_master_enable; // RULE6 RULE8
    assign wake_req = change_summary_flag && change_irq_master_enable; // RULE13 RULE14

    // read mux; unmapped and reserved bits read as zero
    always_comb begin
        next_rdata = word_reset;
        if (req.addr[11:6] == 6'h00 && req.addr[1:0] == 2'h0) begin
            unique case (sub)
                2'h0: next_rdata[7:0] = cfg[grp].rise_enable_reg;
                2'h1: next_rdata[7:0] = cfg[grp].fall_enable_reg;
                2'h2: next_rdata[7:0] = flags[grp];
                2'h3: next_rdata = word_reset;
            endcase
        end else if (req.addr == periph_irq_enable_0_off) begin
            next_rdata[master_enable_bit] = change_irq_master_enable;
        end else if (req.addr == periph_irq_request_0_off) begin
            next_rdata[summary_flag_bit] = change_summary_flag; // RULE9
        end
    end

    // read data registered in the setup cycle so it is stable in the access cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= word_reset;
        end else if (req.sel && !req.enable && !req.write) begin
            prdata <= next_rdata;
        end
    end

    irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !change_irq_master_enable |-> !change_irq)
        else $error("interrupt raised with master enable clear"); // RULE8

    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (change_irq_master_enable && flags[1] != 8'h00) |-> change_irq)
        else $error("flag set but interrupt low"); // RULE6

    wake_match_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wake_req == change_irq)
        else $error("wake request differs from interrupt"); // RULE13

    summary_or_a: assert property (@(posedge mclk) disable iff (!rst_b)
        change_summary_flag == (flags[3] != 8'h00 || flags[0] != 8'h00
            || flags[1] != 8'h00 || flags[2] != 8'h00))
        else $error("summary flag does not match flags"); // RULE9

    e_unimpl_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ((flags[3] | cfg[3].rise_enable_reg | cfg[3].fall_enable_reg) & ~group_e_mask) == 8'h00)
        else $error("group e unimplemented bit set"); // RULE16

    flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (flag_wr[0] && req.wdata[7:0] == 8'h00 && hits[0] == 8'h00) |=> flags[0] == 8'h00)
        else $error("flag write of zero did not clear"); // RULE10

    rise_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
        rise_wr[2] |=> cfg[2].rise_enable_reg == $past(req.wdata[7:0]))
        else $error("rise enable write not stored"); // RULE2

    master_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (wr_fire && req.addr == periph_irq_enable_0_off)
            |=> change_irq_master_enable == $past(req.wdata[master_enable_bit]))
        else $error("master enable write not stored"); // RULE7
endmodule

/* dv/pin_source.sv */
// far-side pin model: drives the port pins at the levels the bench commands
`timescale 1ns/10ps
module pin_source (
    input wire logic mclk,
    input wire logic [24:0] level,
    output logic [7:0] grp_a,
    output logic [7:0] grp_b,
    output logic [7:0] grp_c,
    output logic pin_e
);
    // pins start low so the synchroniser never sees an unknown level
    initial begin
        {pin_e, grp_c, grp_b, grp_a} = 25'h0;
    end
    // pins move just after an edge; the block must not assume any phase
    always @(posedge mclk) begin
        {pin_e, grp_c, grp_b, grp_a} <= level;
    end
endmodule

/* dv/pin_change_interrupt_test.sv */
// self-checking bench for the pin change interrupt block
`timescale 1ns/10ps
module pin_change_interrupt_test import pin_change_pkg::*;;
    typedef struct {
        logic [11:0] base;
        logic [7:0] rise, fall, p0, p1, mask, flags;
    } row_t;
    logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, msk;
    logic pready, pslverr, change_irq, wake_req, er, pe;
    logic [7:0] pa, pb, pc;
    logic [24:0] level = 25'h0;
    logic [3:0] strb = 4'hf;
    int n_fail = 0, n_tests = 0, cycles = 0;
    // group base, enables, pin levels before and after, implemented bits, flags expected
    row_t rows [6] = '{
        '{12'h000, 8'h0f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h0f},
        '{12'h010, 8'h00, 8'hf0, 8'hff, 8'h00, 8'hff, 8'hf0},
        '{12'h020, 8'h0f, 8'hf0, 8'h55, 8'haa, 8'hff, 8'h5a},
        '{12'h010, 8'hff, 8'hff, 8'h0f, 8'hf0, 8'hff, 8'hff},
        '{12'h020, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00},
        '{12'h030, 8'hff, 8'hff, 8'h00, 8'hff, 8'h08, 8'h08}
    };

    pin_source partner (.mclk(mclk), .level(level), .grp_a(pa), .grp_b(pb), .grp_c(pc),
        .pin_e(pe));
    pin_change_interrupt DUT (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_group_a(pa), .pin_group_b(pb),
        .pin_group_c(pc), .group_e_pin_three(pe), .change_irq(change_irq),
        .wake_req(wake_req));

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one apb transfer with an idle cycle first, so strobes never change twice at one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        w = 0;
        // request held until the rising edge that samples pready high
        do begin
            @(posedge mclk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // every mapped word and every hole between them must read zero
    task automatic all_zero();
        for (int a = 0; a <= 'h44; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            check("reset value", rd, 32'h0);
        end
    endtask

    initial begin
        forever #20 mclk = ~mclk;
    end
    // hang guard: the whole run needs well under this many cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        tick(8);
        rst_b <= 1'b1;
        all_zero();
        foreach (rows[i]) begin
            apb(1'b1, rows[i].base, {24'h0, rows[i].rise});
            apb(1'b1, rows[i].base + 12'h4, {24'h0, rows[i].fall});
            level <= {rows[i].p0[3], {3{rows[i].p0}}};
            tick(6);
            apb(1'b1, rows[i].base + 12'h8, 32'h0);
            level <= {rows[i].p1[3], {3{rows[i].p1}}};
            tick(6);
            apb(1'b0, rows[i].base, 32'h0);
            check("rise enable", rd, {24'h0, rows[i].rise & rows[i].mask});
            apb(1'b0, rows[i].base + 12'h8, 32'h0);
            check("change flags", rd, {24'h0, rows[i].flags});
            apb(1'b1, rows[i].base, 32'h0);
            apb(1'b1, rows[i].base + 12'h4, 32'h0);
            apb(1'b1, rows[i].base + 12'h8, 32'h0);
        end
        // master enable still clear: flags catch edges but no interrupt
        apb(1'b1, group_a_rise_enable_off, 32'h0000_00ff);
        level <= 25'h0;
        tick(6);
        level <= 25'h0ff;
        tick(6);
        apb(1'b0, group_a_change_flags_off, 32'h0);
        check("flags master off", rd, 32'h0000_00ff);
        check("irq master off", change_irq, 32'h0);
        apb(1'b0, periph_irq_request_0_off, 32'h0);
        check("summary flag", rd, 32'h1 << summary_flag_bit);
        apb(1'b1, periph_irq_enable_0_off, 32'h1 << master_enable_bit);
        apb(1'b0, periph_irq_enable_0_off, 32'h0);
        check("master enable", rd, 32'h1 << master_enable_bit);
        check("irq master on", change_irq, 32'h1);
        check("wake request", wake_req, 32'h1);
        // software clear by read, invert, and-back
        apb(1'b0, group_a_change_flags_off, 32'h0);
        msk = rd ^ 32'h0000_00ff;
        apb(1'b0, group_a_change_flags_off, 32'h0);
        apb(1'b1, group_a_change_flags_off, rd & msk);
        apb(1'b0, group_a_change_flags_off, 32'h0);
        check("flags cleared", rd, 32'h0);
        check("irq cleared", change_irq, 32'h0);
        // falling edge timed to land on the access edge of a clearing write
        apb(1'b1, group_a_fall_enable_off, 32'h0000_0001);
        level <= 25'h0fe;
        tick(1);
        apb(1'b1, group_a_change_flags_off, 32'h0);
        apb(1'b0, group_a_change_flags_off, 32'h0);
        check("edge beats write", rd, 32'h0000_0001);
        // a write with its byte strobe low must be ignored
        strb <= 4'h0;
        apb(1'b1, group_b_rise_enable_off, 32'h0000_00ff);
        strb <= 4'hf;
        apb(1'b0, group_b_rise_enable_off, 32'h0);
        check("strobe low write", rd, 32'h0);
        check("ready", pready, 32'h1);
        apb(1'b0, 12'hffc, 32'h0);
        check("unmapped error", er, 32'h1);
        check("unmapped data", rd, 32'h0);
        // second reset with a flag and the master enable set
        rst_b <= 1'b0;
        tick(3);
        check("irq in reset", change_irq, 32'h0);
        rst_b <= 1'b1;
        all_zero();
        end_of_test();
    end
endmodule
